// >>> hdl/prc_pkg.sv
package prc_pkg;
	// Sampling clock period and timestamp resolution, in picoseconds
	localparam int CLK_PERIOD_PS = 50000;
	localparam int TS_RES_PS     = 125;
	localparam int TS_W          = 64;
	// Timestamp advance per clock, in sub-sample units
	localparam logic [TS_W-1:0] TS_STEP = TS_W'(CLK_PERIOD_PS / TS_RES_PS);
	localparam logic [TS_W-1:0] TS_ZERO = 64'h0;

	// Output word: one metadata package is eight bytes
	localparam int PKG_W     = 64;
	localparam int PK_TS_W   = 32;
	localparam int PK_PEAK_W = 16;
	localparam int PK_TOT_W  = 16;
	localparam logic [PKG_W-1:0] WORD_ZERO = 64'h0;

	// Collection modes
	localparam logic [2:0] MODE_RAW  = 3'h0;
	localparam logic [2:0] MODE_META = 3'h1;
	localparam logic [2:0] MODE_NTH  = 3'h2;
	localparam logic [2:0] MODE_ALL  = 3'h3;
	localparam logic [2:0] MODE_PAD  = 3'h4;

	// Frame trigger sources
	localparam logic [1:0] TSRC_SW   = 2'h0;
	localparam logic [1:0] TSRC_INT  = 2'h1;
	localparam logic [1:0] TSRC_EXT  = 2'h2;
	localparam logic [1:0] TSRC_SYNC = 2'h3;

	// Timestamp reset event sources
	localparam logic [1:0] TRST_NONE = 2'h0;
	localparam logic [1:0] TRST_EXT  = 2'h1;
	localparam logic [1:0] TRST_SYNC = 2'h2;

	// Pin index in the synchroniser
	localparam int PIN_EXT  = 0;
	localparam int PIN_SYNC = 1;

	// Record builder states, one-hot
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_REC  = 4'h2,
		ST_PAD  = 4'h4,
		ST_META = 4'h8
	} prc_state_t;
endpackage : prc_pkg

// >>> hdl/prc_pin_sync.sv
`timescale 1ns/10ps
// Three-stage pin synchroniser with agreement filter and rise pulse
module prc_pin_sync #(
	parameter int W = 2
) (
	// Clock and reset
	input  wire logic         mclk,
	input  wire logic         sys_rst,
	// Raw pins
	input  wire logic [W-1:0] pin,
	// Filtered level and one-cycle rise
	output logic      [W-1:0] lvl,
	output logic      [W-1:0] rise
);
	initial begin
		if (W < 1) $error("prc_pin_sync: W must be at least 1");
	end

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic s1, s2, s3;    // Stage 1 feeds only stage 2
			logic next_lvl;      // Accepted level
			logic next_rise;     // Edge of accepted level

			// Level changes only once stages two and three agree
			always_comb begin
				next_lvl  = (s2 == s3) ? s3 : lvl[i];
				next_rise = next_lvl & ~lvl[i];
			end

			// Register the chain
			always_ff @(posedge mclk or posedge sys_rst) begin
				if (sys_rst) begin
					s1      <= 1'b0;
					s2      <= 1'b0;
					s3      <= 1'b0;
					lvl[i]  <= 1'b0;
					rise[i] <= 1'b0;
				end else begin
					s1      <= pin[i];
					s2      <= s1;
					s3      <= s2;
					lvl[i]  <= next_lvl;
					rise[i] <= next_rise;
				end
			end
		end
	endgenerate
endmodule : prc_pin_sync

// >>> hdl/prc_chmux.sv
`timescale 1ns/10ps
// Any-channel to engine multiplexer, registered
module prc_chmux #(
	parameter int NCH = 4,
	parameter int DW  = 16
) (
	// Clock and reset
	input  wire logic                   mclk,
	input  wire logic                   sys_rst,
	// All input channels
	input  wire logic [NCH-1:0][DW-1:0] ch_data,
	input  wire logic [NCH-1:0]         ch_roi,
	input  wire logic [$clog2(NCH)-1:0] ch_sel,
	// Selected channel for the engine
	output logic      [DW-1:0]          eng_data,
	output logic                        eng_roi
);
	initial begin
		if (NCH < 2) $error("prc_chmux: NCH must be at least 2");
	end

	logic [DW-1:0] next_data;   // Selected sample
	logic          next_roi;    // Selected region of interest

	// Pick one channel; an out-of-range select gives no pulses
	always_comb begin
		next_data = '0;
		next_roi  = 1'b0;
		if (int'(ch_sel) < NCH) begin
			next_data = ch_data[ch_sel];
			next_roi  = ch_roi[ch_sel];
		end
	end

	// Register keeps data and region aligned
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			eng_data <= '0;
			eng_roi  <= 1'b0;
		end else begin
			eng_data <= next_data;
			eng_roi  <= next_roi;
		end
	end
endmodule : prc_chmux

// >>> hdl/prc_collector.sv
`timescale 1ns/10ps
// Overview of operation
// [R1] Every-Nth mode forwards one record in N
// [R2] All-inclusive mode collects pulses after frame trigger
// [R3] Overlapping pulse regions merge into one record
// [R4] All-inclusive records continue until padding offset
// [R5] Short frame gets padding up to minimum length
// [R6] All-inclusive rejects pulses after offset until trigger
// [R7] All-inclusive emits at most one padding record
// [R8] Padding mode detects always, padding trigger frames
// [R9] Padding mode pads repeatedly until minimum reached
// [R10] Padding mode pulse truncates padding in progress
// [R11] Padding mode offset is its own parameter
// [R12] Padding trigger shares detection trigger sources
// [R13] No padding before padding offset elapses
// [R14] Zero minimum frame length disables padding
// [R15] Padding package is all-zero metadata package
// [R16] Padding record zero data, disregard flag set
// [R17] Header timestamp counts clocks, sub-sample units
// [R18] Timestamp reset by power, software, trig, sync
// [R19] One timestamp per record: window or pulse
// [R20] Any input channel routes to this engine
// [R21] Metadata package: timestamp, peak, width
// [R22] Padding sized to remaining minimum shortfall
module prc_collector #(
	parameter int NCH = 4,
	parameter int DW  = 16,
	parameter int LW  = 16,
	parameter int NW  = 16
) (
	// Clock and reset
	input  wire logic                   mclk,
	input  wire logic                   sys_rst,
	// Sample channels and per-channel level trigger region
	input  wire logic [NCH-1:0][DW-1:0] ch_data,
	input  wire logic [NCH-1:0]         ch_roi,
	input  wire logic [$clog2(NCH)-1:0] ch_sel,
	// Pulse metrics from the analysis stage
	input  wire logic                   meta_valid,
	input  wire logic [prc_pkg::PK_TS_W-1:0]   meta_peak_ts,
	input  wire logic [prc_pkg::PK_PEAK_W-1:0] meta_peak,
	input  wire logic [prc_pkg::PK_TOT_W-1:0]  meta_tot,
	// Trigger sources
	input  wire logic                   sw_trig,
	input  wire logic                   int_trig,
	input  wire logic                   ext_trig_pin,
	input  wire logic                   ext_sync_pin,
	input  wire logic [1:0]             trig_src,
	// Configuration
	input  wire logic [2:0]             mode,
	input  wire logic [NW-1:0]          nth_n,
	input  wire logic [LW-1:0]          det_win_len,
	input  wire logic [LW-1:0]          pad_offset,
	input  wire logic [LW-1:0]          min_frame_len,
	// Timestamp control
	input  wire logic                   sw_ts_rst,
	input  wire logic [1:0]             ts_rst_src,
	// Record stream to host
	output logic                        rec_valid,
	output logic [prc_pkg::PKG_W-1:0]   rec_data,
	output logic                        rec_first,
	output logic                        rec_last,
	output logic                        rec_pad,
	output logic [prc_pkg::TS_W-1:0]    rec_ts
);
	initial begin
		if (DW > prc_pkg::PKG_W) $error("prc_collector: DW too wide");
		if (LW < 2 || NW < 1) $error("prc_collector: bad LW or NW");
	end

	// True in the modes that frame and pad raw records
	function automatic logic f_raw_pad(input logic [2:0] m);
		return (m == prc_pkg::MODE_ALL) || (m == prc_pkg::MODE_PAD);
	endfunction : f_raw_pad

	// Select the frame trigger from its source
	function automatic logic f_trig(input logic [1:0] s, input logic sw,
	                                input logic it, input logic [1:0] pr);
		case (s)
			prc_pkg::TSRC_SW:  return sw;
			prc_pkg::TSRC_INT: return it;
			prc_pkg::TSRC_EXT: return pr[prc_pkg::PIN_EXT];
			default:           return pr[prc_pkg::PIN_SYNC];
		endcase
	endfunction : f_trig

	logic [DW-1:0]          smp;        // Selected sample
	logic                   roi;        // Selected pulse region
	logic [1:0]             pin_rise;   // Synchronised pin edges
	logic                   ftrig;      // Frame trigger this cycle
	logic                   m_meta;     // Metadata mode
	logic                   m_pad;      // Padding mode, no window
	logic                   pulse_ok;   // Pulse may open a record
	logic                   pad_need;   // Frame short after offset
	logic [LW-1:0]          len1;       // Frame length plus one word
	logic [LW-1:0]          offs_len;   // Active padding offset

	// Channel routing and pin synchronisers
	prc_chmux #(.NCH(NCH), .DW(DW)) u_mux (   // [R20]
		.mclk     (mclk),
		.sys_rst  (sys_rst),
		.ch_data  (ch_data),
		.ch_roi   (ch_roi),
		.ch_sel   (ch_sel),
		.eng_data (smp),
		.eng_roi  (roi)
	);
	prc_pin_sync #(.W(2)) u_sync (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.pin     ({ext_sync_pin, ext_trig_pin}),
		.lvl     (),
		.rise    (pin_rise)
	);

	// Timestamp counter
	logic [prc_pkg::TS_W-1:0] ts_cnt, next_ts_cnt;
	logic                     ts_clr;   // Any reset event

	// Software, trigger pin or sync pin may zero the count
	always_comb begin
		ts_clr = sw_ts_rst                                        // [R18]
		       | (ts_rst_src == prc_pkg::TRST_EXT
		          & pin_rise[prc_pkg::PIN_EXT])
		       | (ts_rst_src == prc_pkg::TRST_SYNC
		          & pin_rise[prc_pkg::PIN_SYNC]);
		next_ts_cnt = ts_clr ? prc_pkg::TS_ZERO
		                     : ts_cnt + prc_pkg::TS_STEP;           // [R17]
	end

	// Power-up clears through the asynchronous reset
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) ts_cnt <= prc_pkg::TS_ZERO;                   // [R18]
		else ts_cnt <= next_ts_cnt;
	end

	// Frame tracking
	logic          frame_act, next_frame_act;   // A frame has begun
	logic          offs_done, next_offs_done;   // Offset elapsed
	logic [LW-1:0] off_cnt, next_off_cnt;       // Cycles into frame
	logic [LW-1:0] frame_len, next_frame_len;   // Words sent in frame
	logic          pad_done, next_pad_done;     // Padding record sent
	logic          len_inc;                     // Word counted now
	logic          pad_start;                   // Padding record opens

	// Decodes shared by both groups
	always_comb begin
		m_meta   = (mode == prc_pkg::MODE_META);
		m_pad    = (mode == prc_pkg::MODE_PAD);
		ftrig    = f_trig(trig_src, sw_trig, int_trig, pin_rise); // [R12]
		offs_len = m_pad ? pad_offset : det_win_len;              // [R11]
		len1     = frame_len + LW'(1);
		pad_need = f_raw_pad(mode) && offs_done                   // [R13]
		         && (min_frame_len != '0)                         // [R14]
		         && (frame_len < min_frame_len);                  // [R5]
		case (mode)
			prc_pkg::MODE_ALL: pulse_ok = frame_act && !offs_done; // [R2] [R6]
			prc_pkg::MODE_PAD: pulse_ok = 1'b1;                    // [R8]
			prc_pkg::MODE_RAW, prc_pkg::MODE_NTH: pulse_ok = 1'b1;
			default:           pulse_ok = 1'b0;
		endcase
	end

	// A trigger restarts offset count and frame length
	always_comb begin
		next_frame_act = frame_act;
		next_offs_done = offs_done;
		next_off_cnt   = off_cnt;
		next_frame_len = len_inc ? len1 : frame_len;
		next_pad_done  = pad_done | pad_start;
		if (ftrig) begin
			next_frame_act = 1'b1;
			next_offs_done = (offs_len == '0);
			next_off_cnt   = '0;
			next_frame_len = '0;
			next_pad_done  = 1'b0;
		end else if (frame_act && !offs_done) begin
			next_off_cnt   = off_cnt + LW'(1);
			next_offs_done = (off_cnt + LW'(1) >= offs_len);       // [R4]
		end
	end

	// Register frame state
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			frame_act <= 1'b0;
			offs_done <= 1'b0;
			off_cnt   <= '0;
			frame_len <= '0;
			pad_done  <= 1'b0;
		end else begin
			frame_act <= next_frame_act;
			offs_done <= next_offs_done;
			off_cnt   <= next_off_cnt;
			frame_len <= next_frame_len;
			pad_done  <= next_pad_done;
		end
	end

	// Record builder
	prc_pkg::prc_state_t st, next_st;
	logic                fwd, next_fwd;            // Record is forwarded
	logic [NW-1:0]       nth_cnt, next_nth_cnt;    // Records since sent
	logic                hdr_pend, next_hdr_pend;  // Header not yet out
	logic                next_valid, next_first, next_last, next_pad;
	logic [prc_pkg::PKG_W-1:0] next_data;
	logic [prc_pkg::TS_W-1:0]  next_ts;

	// One word per cycle; rec_last may stand alone to close
	always_comb begin
		next_st       = st;
		next_fwd      = fwd;
		next_nth_cnt  = nth_cnt;
		next_hdr_pend = hdr_pend;
		next_valid    = 1'b0;
		next_first    = 1'b0;
		next_last     = 1'b0;
		next_pad      = rec_pad;
		next_data     = rec_data;
		next_ts       = rec_ts;
		len_inc       = 1'b0;
		pad_start     = 1'b0;
		case (st)
			prc_pkg::ST_IDLE: begin
				if (m_meta && ftrig) begin
					// Window start stamps the metadata record
					next_st       = prc_pkg::ST_META;
					next_hdr_pend = 1'b1;
					next_ts       = ts_cnt;                        // [R19]
					next_pad      = 1'b0;
				end else if (roi && pulse_ok && !m_meta) begin
					// Pulse start stamps the raw record
					next_st    = prc_pkg::ST_REC;
					next_fwd   = 1'b1;
					if (mode == prc_pkg::MODE_NTH) begin
						next_fwd     = (nth_cnt == '0);              // [R1]
						next_nth_cnt = (nth_cnt + NW'(1) >= nth_n)
						             ? '0 : nth_cnt + NW'(1);
					end
					next_valid = next_fwd;
					next_first = next_fwd;
					next_pad   = 1'b0;
					next_data  = prc_pkg::PKG_W'(smp);
					next_ts    = ts_cnt;                           // [R19]
					len_inc    = next_fwd;
				end else if (pad_need && !ftrig
				             && (m_pad || !pad_done)) begin  // [R7] [R9]
					// Open a padding record of zeros; never on a trigger,
					// which restarts the offset and would pad too early
					pad_start  = 1'b1;
					next_valid = 1'b1;
					next_first = 1'b1;
					next_pad   = 1'b1;                             // [R16]
					next_data  = prc_pkg::WORD_ZERO;
					next_ts    = ts_cnt;
					len_inc    = 1'b1;
					if (len1 >= min_frame_len) begin               // [R22]
						next_last = 1'b1;
						next_st   = prc_pkg::ST_IDLE;
					end else begin
						next_st   = prc_pkg::ST_PAD;
					end
				end
			end
			prc_pkg::ST_REC: begin
				// Region stays high while overlapping pulses merge
				next_valid = fwd && roi;                           // [R3]
				next_data  = prc_pkg::PKG_W'(smp);
				len_inc    = fwd && roi;
				if (!roi) begin
					next_last = fwd;
					next_st   = prc_pkg::ST_IDLE;
				end
			end
			prc_pkg::ST_PAD: begin
				if (ftrig || (m_pad && roi)) begin
					// Cut short; the pulse opens next cycle
					next_last = 1'b1;                              // [R10]
					next_st   = prc_pkg::ST_IDLE;
				end else begin
					next_valid = 1'b1;
					next_data  = prc_pkg::WORD_ZERO;               // [R16]
					len_inc    = 1'b1;
					if (len1 >= min_frame_len) begin               // [R22]
						next_last = 1'b1;
						next_st   = prc_pkg::ST_IDLE;
					end
				end
			end
			prc_pkg::ST_META: begin
				next_pad = 1'b0;
				if (ftrig) begin
					// New window closes this record and opens the next
					next_last     = 1'b1;
					next_first    = hdr_pend;
					next_hdr_pend = 1'b1;
					next_ts       = ts_cnt;                        // [R19]
				end else if (!offs_done) begin
					if (meta_valid) begin
						next_valid    = 1'b1;
						next_first    = hdr_pend;
						next_hdr_pend = 1'b0;
						next_data     = {meta_peak_ts, meta_peak,
						                 meta_tot};                // [R21]
						len_inc       = 1'b1;
					end
				end else if ((min_frame_len != '0)                 // [R14]
				          && (frame_len < min_frame_len)) begin    // [R5]
					next_valid    = 1'b1;
					next_first    = hdr_pend;
					next_hdr_pend = 1'b0;
					next_data     = prc_pkg::WORD_ZERO;            // [R15]
					len_inc       = 1'b1;
					next_last     = (len1 >= min_frame_len);
					if (next_last) next_st = prc_pkg::ST_IDLE;
				end else begin
					next_last     = 1'b1;
					next_first    = hdr_pend;
					next_hdr_pend = 1'b0;
					next_st       = prc_pkg::ST_IDLE;
				end
			end
			default: next_st = prc_pkg::ST_IDLE;
		endcase
	end

	// Register builder state and the output word
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			st        <= prc_pkg::ST_IDLE;
			fwd       <= 1'b0;
			nth_cnt   <= '0;
			hdr_pend  <= 1'b0;
			rec_valid <= 1'b0;
			rec_first <= 1'b0;
			rec_last  <= 1'b0;
			rec_pad   <= 1'b0;
			rec_data  <= prc_pkg::WORD_ZERO;
			rec_ts    <= prc_pkg::TS_ZERO;
		end else begin
			st        <= next_st;
			fwd       <= next_fwd;
			nth_cnt   <= next_nth_cnt;
			hdr_pend  <= next_hdr_pend;
			rec_valid <= next_valid;
			rec_first <= next_first;
			rec_last  <= next_last;
			rec_pad   <= next_pad;
			rec_data  <= next_data;
			rec_ts    <= next_ts;
		end
	end

	// Checks on the record stream
	AST_PAD_AFTER_OFFSET: assert property (@(posedge mclk) // [R13]
		disable iff (sys_rst) rec_valid && rec_pad |-> $past(offs_done))
		else $error("padding word before padding offset");
	AST_PAD_ZERO_MIN: assert property (@(posedge mclk) // [R14]
		disable iff (sys_rst)
		rec_valid && rec_pad |-> $past(min_frame_len) != '0)
		else $error("padding with zero minimum frame length");
	AST_PAD_DATA_ZERO: assert property (@(posedge mclk) // [R16]
		disable iff (sys_rst) rec_valid && rec_pad |-> rec_data == '0)
		else $error("padding record data not zero");
	AST_ALL_REJECT: assert property (@(posedge mclk) // [R6]
		disable iff (sys_rst)
		mode == prc_pkg::MODE_ALL && offs_done && !ftrig
		&& st == prc_pkg::ST_IDLE && roi |=> !(rec_first && !rec_pad))
		else $error("pulse accepted after padding offset");
	AST_ALL_ONE_PAD: assert property (@(posedge mclk) // [R7]
		disable iff (sys_rst)
		mode == prc_pkg::MODE_ALL && pad_done && !ftrig
		|=> !(rec_first && rec_pad))
		else $error("second padding record in one frame");
	AST_TS_STEP: assert property (@(posedge mclk) // [R17]
		disable iff (sys_rst)
		!ts_clr |=> ts_cnt == $past(ts_cnt) + prc_pkg::TS_STEP)
		else $error("timestamp did not advance by one step");
	AST_TS_SW_CLR: assert property (@(posedge mclk) // [R18]
		disable iff (sys_rst) sw_ts_rst |=> ts_cnt == '0)
		else $error("software timestamp reset ignored");
	AST_PAD_TRUNC: assert property (@(posedge mclk) // [R10]
		disable iff (sys_rst)
		m_pad && st == prc_pkg::ST_PAD && roi
		|=> rec_last && !rec_valid ##1 st == prc_pkg::ST_REC || !roi)
		else $error("pulse did not cut padding short");
endmodule : prc_collector

// >>> bench/prc_host_model.sv
`timescale 1ns/10ps
// Host end of the record stream: tallies records, words and headers
module prc_host_model (
	// Clock and reset
	input  wire logic                      mclk,
	input  wire logic                      sys_rst,
	// Record stream from the engine
	input  wire logic                      rec_valid,
	input  wire logic [prc_pkg::PKG_W-1:0] rec_data,
	input  wire logic                      rec_first,
	input  wire logic                      rec_last,
	input  wire logic                      rec_pad,
	input  wire logic [prc_pkg::TS_W-1:0]  rec_ts,
	// Tallies for the bench
	output logic      [15:0]               n_rec,
	output logic      [15:0]               n_pad_rec,
	output logic      [15:0]               n_words,
	output logic      [15:0]               n_pad_words,
	output logic      [15:0]               n_last,
	output logic                           pad_bad,
	output logic      [prc_pkg::PKG_W-1:0] first_word,
	output logic      [prc_pkg::TS_W-1:0]  ts_prev,
	output logic      [prc_pkg::TS_W-1:0]  ts_last
);
	// The host never stalls: the stream has no back-pressure to apply
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			n_rec       <= 16'h0;
			n_pad_rec   <= 16'h0;
			n_words     <= 16'h0;
			n_pad_words <= 16'h0;
			n_last      <= 16'h0;
			pad_bad     <= 1'b0;
			first_word  <= 64'h0;
			ts_prev     <= 64'h0;
			ts_last     <= 64'h0;
		end else begin
			// One header stamp per record, taken with its first word
			if (rec_first) begin
				n_rec   <= n_rec + 16'h1;
				ts_prev <= ts_last;
				ts_last <= rec_ts;
				if (n_rec == 16'h0)
					first_word <= rec_data;
				if (rec_pad)
					n_pad_rec <= n_pad_rec + 16'h1;
			end
			// Closing strobes, with or without a word of their own
			if (rec_last)
				n_last <= n_last + 16'h1;
			if (rec_valid) begin
				n_words <= n_words + 16'h1;
				// Disregarded records must still carry zero data
				if (rec_pad) begin
					n_pad_words <= n_pad_words + 16'h1;
					if (rec_data !== 64'h0)
						pad_bad <= 1'b1;
				end
			end
		end
	end
endmodule : prc_host_model

// >>> bench/testbench.sv
`timescale 1ns/10ps
// Directed scenarios for the record collector
module testbench;
	// Clock, reset and stimulus
	logic                  mclk, sys_rst;
	logic [3:0][15:0]      ch_data;
	logic [3:0]            ch_roi;
	logic [1:0]            ch_sel, trig_src, ts_rst_src;
	logic                  meta_valid, sw_trig, sw_ts_rst;
	logic                  int_trig, ext_trig_pin, ext_sync_pin;
	logic [31:0]           meta_peak_ts;
	logic [15:0]           meta_peak, meta_tot, nth_n;
	logic [15:0]           det_win_len, pad_offset, min_frame_len;
	logic [2:0]            mode;
	// Engine outputs and host tallies
	logic                  rec_valid, rec_first, rec_last, rec_pad;
	logic [63:0]           rec_data, rec_ts, first_word, ts_prev, ts_last;
	logic [15:0]           n_rec, n_pad_rec, n_words, n_pad_words, n_last;
	logic                  pad_bad;
	int                    errors, checks_done;

	prc_collector u_dut (.mclk(mclk), .sys_rst(sys_rst), .ch_data(ch_data),
		.ch_roi(ch_roi), .ch_sel(ch_sel), .meta_valid(meta_valid),
		.meta_peak_ts(meta_peak_ts), .meta_peak(meta_peak),
		.meta_tot(meta_tot), .sw_trig(sw_trig), .int_trig(int_trig),
		.ext_trig_pin(ext_trig_pin), .ext_sync_pin(ext_sync_pin),
		.trig_src(trig_src),
		.mode(mode), .nth_n(nth_n), .det_win_len(det_win_len),
		.pad_offset(pad_offset), .min_frame_len(min_frame_len),
		.sw_ts_rst(sw_ts_rst), .ts_rst_src(ts_rst_src), .rec_valid(rec_valid),
		.rec_data(rec_data), .rec_first(rec_first), .rec_last(rec_last),
		.rec_pad(rec_pad), .rec_ts(rec_ts));

	prc_host_model u_host (.mclk(mclk), .sys_rst(sys_rst),
		.rec_valid(rec_valid), .rec_data(rec_data), .rec_first(rec_first),
		.rec_pad(rec_pad), .rec_ts(rec_ts), .rec_last(rec_last),
		.n_rec(n_rec), .n_last(n_last),
		.n_pad_rec(n_pad_rec), .n_words(n_words),
		.n_pad_words(n_pad_words), .pad_bad(pad_bad),
		.first_word(first_word), .ts_prev(ts_prev), .ts_last(ts_last));

	// 20 MHz sampling clock
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	// Inputs move one fixed step after each rising edge
	task step(input int n);
		repeat (n) begin
			@(posedge mclk);
			#1;
		end
	endtask : step

	task check(input string what, input logic [63:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task end_of_test;
		$display("Checks %0d, mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : end_of_test

	// Fresh engine and host tallies for every scenario
	task do_reset(input logic [2:0] m);
		sys_rst = 1'b1;
		mode = m;
		step(5);
		sys_rst = 1'b0;
		step(1);
	endtask : do_reset

	// Region of interest on channel 2, samples counting up from base
	task pulse(input int len, input logic [15:0] base);
		for (int i = 0; i < len; i++) begin
			ch_roi[2] = 1'b1;
			ch_data[2] = base + 16'(i);
			step(1);
		end
		ch_roi[2] = 1'b0;
	endtask : pulse

	task trig;
		sw_trig = 1'b1;
		step(1);
		sw_trig = 1'b0;
	endtask : trig

	// Two separate regions give two records stamped ten clocks apart
	task sc_raw;
		do_reset(prc_pkg::MODE_RAW);
		pulse(6, 16'h0100);
		step(4);
		pulse(3, 16'h0200);
		step(10);
		check("raw records", n_rec, 64'h2);
		check("raw words", n_words, 64'h9);
		check("raw ends", n_last, 64'h2);
		check("raw first word", first_word, 64'h0100);
		check("stamp step", ts_last - ts_prev, 10 * prc_pkg::TS_STEP);
		sw_ts_rst = 1'b1;
		step(1);
		sw_ts_rst = 1'b0;
		pulse(1, 16'h0300);
		step(6);
		check("stamp clear", 64'(ts_last < 20 * prc_pkg::TS_STEP), 64'h1);
	endtask : sc_raw

	task sc_nth;
		nth_n = 16'h2;
		do_reset(prc_pkg::MODE_NTH);
		repeat (4) begin
			pulse(2, 16'h0400);
			step(4);
		end
		step(6);
		check("nth records", n_rec, 64'h2);
		check("nth words", n_words, 64'h4);
		check("nth ends", n_last, 64'h2);
	endtask : sc_nth

	// Window of 20, one pulse inside, one after the offset
	task sc_all;
		det_win_len = 16'd20;
		min_frame_len = 16'd12;
		do_reset(prc_pkg::MODE_ALL);
		pulse(3, 16'h0500);
		trig;
		step(5);
		pulse(4, 16'h0600);
		step(35);
		pulse(3, 16'h0700);
		step(20);
		check("all records", n_rec, 64'h2);
		check("all pad records", n_pad_rec, 64'h1);
		check("all pad words", n_pad_words, 64'h8);
		check("all words", n_words, 64'd12);
		check("all pad data", pad_bad, 64'h0);
		trig;
		step(3);
		pulse(2, 16'h0800);
		step(8);
		check("all next frame", n_rec, 64'h3);
	endtask : sc_all

	task sc_pad;
		pad_offset = 16'd10;
		min_frame_len = 16'd8;
		do_reset(prc_pkg::MODE_PAD);
		trig;
		// Last instant at which a word launched before the offset shows
		step(11);
		check("pad before offset", n_words, 64'h0);
		step(28);
		check("pad records", n_pad_rec, 64'h1);
		check("pad words", n_pad_words, 64'h8);
		check("pad data", pad_bad, 64'h0);
		min_frame_len = 16'd0;
		trig;
		step(40);
		check("pad disabled", n_rec, 64'h1);
		pulse(3, 16'h0900);
		step(8);
		check("pad always detects", n_rec, 64'h2);
	endtask : sc_pad

	// A pulse cuts a running padding record short
	task sc_trunc;
		int n;
		pad_offset = 16'd5;
		min_frame_len = 16'd30;
		do_reset(prc_pkg::MODE_PAD);
		trig;
		n = 0;
		while (n_pad_words == 16'h0 && n < 50) begin
			step(1);
			n++;
		end
		if (n == 50) begin
			errors++;
			$display("Error padding start not seen");
			end_of_test;
		end
		step(3);
		pulse(3, 16'h0a00);
		step(60);
		check("trunc pad records", n_pad_rec, 64'h2);
		check("trunc frame full", n_words, 64'd30);
	endtask : sc_trunc

	task sc_meta;
		det_win_len = 16'd10;
		min_frame_len = 16'd4;
		trig_src = prc_pkg::TSRC_INT;
		do_reset(prc_pkg::MODE_META);
		// Software strobe is not the selected source and opens nothing
		trig;
		step(3);
		check("meta sw ignored", n_rec, 64'h0);
		int_trig = 1'b1;
		step(1);
		int_trig = 1'b0;
		step(3);
		meta_valid = 1'b1;
		meta_peak_ts = 32'h0000_1234;
		meta_peak = 16'h0abc;
		meta_tot = 16'h0007;
		step(1);
		meta_valid = 1'b0;
		step(30);
		check("meta records", n_rec, 64'h1);
		check("meta package", first_word, 64'h0000_1234_0abc_0007);
		check("meta words", n_words, 64'h4);
	endtask : sc_meta

	// Trigger pin opens a padding frame; sync pin rise clears the stamp
	task sc_pins;
		trig_src = prc_pkg::TSRC_EXT;
		ts_rst_src = prc_pkg::TRST_SYNC;
		pad_offset = 16'd4;
		min_frame_len = 16'd2;
		do_reset(prc_pkg::MODE_PAD);
		ext_trig_pin = 1'b1;
		step(20);
		check("pin frame pads", n_pad_rec, 64'h1);
		check("pin frame words", n_pad_words, 64'h2);
		ext_sync_pin = 1'b1;
		step(6);
		pulse(1, 16'h0b00);
		step(6);
		check("sync clear", 64'(ts_last <= 4 * prc_pkg::TS_STEP), 64'h1);
	endtask : sc_pins

	initial begin
		errors = 0;
		checks_done = 0;
		sys_rst = 1'b1;
		ch_data = {16'h0, 16'h0, 16'h0, 16'hdead};
		// Channel 0 is busy all the time but never selected
		ch_roi = 4'h1;
		ch_sel = 2'h2;
		{meta_valid, sw_trig, sw_ts_rst, int_trig} = 4'h0;
		{ext_trig_pin, ext_sync_pin} = 2'h0;
		trig_src = prc_pkg::TSRC_SW;
		ts_rst_src = prc_pkg::TRST_NONE;
		meta_peak_ts = 32'h0;
		meta_peak = 16'h0;
		meta_tot = 16'h0;
		nth_n = 16'h0;
		det_win_len = 16'h0;
		pad_offset = 16'h0;
		min_frame_len = 16'h0;
		mode = prc_pkg::MODE_RAW;
		sc_raw;
		sc_nth;
		sc_all;
		sc_pad;
		sc_trunc;
		sc_meta;
		sc_pins;
		end_of_test;
	end
endmodule : testbench
